// file: pkg/eepc_if.sv
// Interface: CPU-side access lines into the EEPROM controller
`timescale 1ns/1ps
interface eepc_if;
	logic        ctrl_wr;   // Control register write strobe
	logic [7:0]  ctrl_wdata;
	logic [7:0]  ctrl_rdata;
	logic        xmove_wr;  // External data move write strobe
	logic        xmove_rd;  // External data move read strobe
	logic [10:0] data_pointer;      // data_pointer low 11 bits
	logic [7:0]  acc;       // Accumulator byte
	logic [7:0]  xmove_rdata;
	logic        xmove_rvalid;
	logic        xram_sel;  // Move routed to external RAM
	modport device (
		input  ctrl_wr, ctrl_wdata, xmove_wr, xmove_rd, data_pointer, acc,
		output ctrl_rdata, xmove_rdata, xmove_rvalid, xram_sel
	);
	modport host (
		output ctrl_wr, ctrl_wdata, xmove_wr, xmove_rd, data_pointer, acc,
		input  ctrl_rdata, xmove_rdata, xmove_rvalid, xram_sel
	);
endinterface : eepc_if

// file: pkg/eepc_pkg.sv
// Package: constants shared by the EEPROM access controller and its CPU-side end
package eepc_pkg;
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int ADDR_W      = 11;
	localparam int ROW_W       = 4;
	localparam int COL_W       = 7;
	localparam int PAGE_BYTES  = 128;
	localparam int DATA_W      = 8;
	// ****************************************************************
	// Control register layout and commands
	// ****************************************************************
	localparam int BUSY_BIT    = 0;
	localparam int SPACE_BIT   = 1;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [3:0] LAUNCH_ARM  = 4'h5;
	localparam logic [3:0] LAUNCH_GO   = 4'hA;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ     = 200;
	localparam int PROG_TIME_US = 10;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	// Host access states
	typedef enum logic [2:0] {
		EEPC_H_IDLE,
		EEPC_H_CTRL,
		EEPC_H_ARM,
		EEPC_H_XMOVE,
		EEPC_H_WAIT,
		EEPC_H_UNMAP
	} eepc_host_e;
endpackage : eepc_pkg

// file: src/eepc_device.sv
// Module: EEPROM column-latch loading, launch and programming controller
`timescale 1ns/1ps
module eepc_device #(
	parameter int PROG_CYCLES = eepc_pkg::PROG_CYCLES
) (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	eepc_if.device    bus,
	output logic      busy_out,
	output logic      prog_done_out
);
	localparam int ROWS = 1 << eepc_pkg::ROW_W;
	localparam int MEM_BYTES = ROWS * eepc_pkg::PAGE_BYTES;

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [7:0]  mem     [MEM_BYTES];
	logic [7:0]  latch   [eepc_pkg::PAGE_BYTES];
	logic [eepc_pkg::PAGE_BYTES-1:0] marker;
	logic [eepc_pkg::ROW_W-1:0] page_row;
	logic        page_valid;
	logic        space_en;
	logic        busy;
	logic        armed;
	logic [31:0] prog_cnt;
	logic [eepc_pkg::COL_W-1:0] prog_col;

	// Decode helpers for the row and column fields
	function automatic logic [eepc_pkg::ROW_W-1:0] row_of(input logic [10:0] a);
		row_of = a[eepc_pkg::ADDR_W-1:eepc_pkg::COL_W];
	endfunction : row_of
	function automatic logic [eepc_pkg::COL_W-1:0] col_of(input logic [10:0] a);
		col_of = a[eepc_pkg::COL_W-1:0];
	endfunction : col_of

	logic ee_wr;
	logic ee_rd;
	logic launch;
	assign ee_wr  = bus.xmove_wr && space_en;
	assign ee_rd  = bus.xmove_rd && space_en;
	// Only a GO that is the next control write after ARM, with no move between, launches; a busy array ignores it
	assign launch = bus.ctrl_wr && armed && !busy
		&& (bus.ctrl_wdata[7:4] == eepc_pkg::LAUNCH_GO);

	// ****************************************************************
	// Control register
	// ****************************************************************
	// Space enable is the only software-writable bit; busy ignores writes
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			space_en <= 1'b0;
		end else if (bus.ctrl_wr) begin
			space_en <= bus.ctrl_wdata[eepc_pkg::SPACE_BIT];
		end
	end

	// Arm on 5xh; any other control write or a move in between disarms
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			armed <= 1'b0;
		end else if (bus.ctrl_wr) begin
			armed <= (bus.ctrl_wdata[7:4] == eepc_pkg::LAUNCH_ARM);
		end else if (bus.xmove_wr || bus.xmove_rd) begin
			armed <= 1'b0;
		end
	end

	// ****************************************************************
	// Column latches
	// ****************************************************************
	// First page written since the last programming owns the latches
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			page_valid <= 1'b0;
			page_row   <= '0;
			marker     <= '0;
		end else if (busy && prog_cnt == 32'd0) begin
			marker     <= '0;
			page_valid <= 1'b0;
		end else if (ee_wr && !busy) begin
			if (!page_valid) begin
				page_valid <= 1'b1;
				page_row   <= row_of(bus.data_pointer);
				marker[col_of(bus.data_pointer)] <= 1'b1;
			end else if (row_of(bus.data_pointer) == page_row) begin
				marker[col_of(bus.data_pointer)] <= 1'b1;
			end
		end
	end

	// Latch data; bytes aimed at another page are dropped
	always_ff @(posedge mclk_in) begin
		if (ee_wr && !busy && (!page_valid || row_of(bus.data_pointer) == page_row)) begin
			latch[col_of(bus.data_pointer)] <= bus.acc;
		end
	end

	// ****************************************************************
	// Programming engine
	// ****************************************************************
	// Busy spans the full programming time, then drops by itself
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			busy     <= 1'b0;
			prog_cnt <= '0;
		end else if (launch) begin
			busy     <= 1'b1;
			prog_cnt <= 32'(PROG_CYCLES - 1);
		end else if (busy) begin
			if (prog_cnt == 32'd0) begin
				busy <= 1'b0;
			end else begin
				prog_cnt <= prog_cnt - 32'd1;
			end
		end
	end

	// Row write: one column per cycle, marked bytes only, within the window
	always_ff @(posedge mclk_in) begin
		if (rst_in || launch) begin
			prog_col <= '0;
		end else if (busy && prog_col != '1) begin
			prog_col <= prog_col + 7'd1;
		end
	end

	// Walks all columns; PROG_CYCLES must be at least the page size
	always_ff @(posedge mclk_in) begin
		if (busy && page_valid && marker[prog_col]) begin
			mem[{page_row, prog_col}] <= latch[prog_col];
		end
	end

	// ****************************************************************
	// Read path and outputs
	// ****************************************************************
	// Reads while busy return no valid strobe
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			bus.xmove_rvalid <= 1'b0;
			bus.xmove_rdata  <= '0;
		end else begin
			bus.xmove_rvalid <= ee_rd && !busy;
			if (ee_rd && !busy) begin
				bus.xmove_rdata <= mem[bus.data_pointer];
			end
		end
	end

	// Register view and status
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			bus.ctrl_rdata <= eepc_pkg::CTRL_RESET;
			bus.xram_sel   <= 1'b1;
			busy_out       <= 1'b0;
			prog_done_out  <= 1'b0;
		end else begin
			bus.ctrl_rdata <= {6'h00, space_en, busy};
			bus.xram_sel   <= !space_en;
			busy_out       <= busy;
			prog_done_out  <= busy && prog_cnt == 32'd0;
		end
	end
endmodule : eepc_device

// file: src/eepc_host.sv
// Module: CPU-side sequencer issuing control writes and data moves
`timescale 1ns/1ps
module eepc_host (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	eepc_if.host             bus,
	input  wire logic        req_in,     // One-cycle request
	input  wire logic [1:0]  op_in,      // 0 read, 1 load latch, 2 launch
	input  wire logic [10:0] addr_in,
	input  wire logic [7:0]  data_in,
	output logic             done_out,
	output logic [7:0]       rdata_out,
	output logic             idle_out
);
	eepc_pkg::eepc_host_e state;
	logic [1:0] op;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Map, move, unmap; launch issues two back-to-back control writes
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state          <= eepc_pkg::EEPC_H_IDLE;
			op             <= '0;
			bus.ctrl_wr    <= 1'b0;
			bus.ctrl_wdata <= '0;
			bus.xmove_wr   <= 1'b0;
			bus.xmove_rd   <= 1'b0;
			bus.data_pointer       <= '0;
			bus.acc        <= '0;
			done_out       <= 1'b0;
			rdata_out      <= '0;
			idle_out       <= 1'b1;
		end else begin
			bus.ctrl_wr  <= 1'b0;
			bus.xmove_wr <= 1'b0;
			bus.xmove_rd <= 1'b0;
			done_out     <= 1'b0;
			case (state)
				eepc_pkg::EEPC_H_IDLE: begin
					idle_out <= 1'b1;
					if (req_in) begin
						op       <= op_in;
						bus.data_pointer <= addr_in;
						bus.acc  <= data_in;
						idle_out <= 1'b0;
						bus.ctrl_wr <= 1'b1;
						if (op_in == 2'd2) begin
							bus.ctrl_wdata <= {eepc_pkg::LAUNCH_ARM, 4'h0};
							state <= eepc_pkg::EEPC_H_ARM;
						end else begin
							bus.ctrl_wdata <= 8'h02; // Map EEPROM
							state <= eepc_pkg::EEPC_H_CTRL;
						end
					end
				end
				eepc_pkg::EEPC_H_ARM: begin
					bus.ctrl_wr    <= 1'b1;
					bus.ctrl_wdata <= {eepc_pkg::LAUNCH_GO, 4'h0};
					state          <= eepc_pkg::EEPC_H_UNMAP;
				end
				eepc_pkg::EEPC_H_CTRL: begin
					bus.xmove_wr <= (op == 2'd1);
					bus.xmove_rd <= (op == 2'd0);
					state <= (op == 2'd0) ? eepc_pkg::EEPC_H_WAIT : eepc_pkg::EEPC_H_XMOVE;
				end
				eepc_pkg::EEPC_H_WAIT: begin
					state <= eepc_pkg::EEPC_H_XMOVE;
				end
				eepc_pkg::EEPC_H_XMOVE: begin
					if (op == 2'd0) begin
						rdata_out <= bus.xmove_rdata;
					end
					bus.ctrl_wr    <= 1'b1;
					bus.ctrl_wdata <= 8'h00; // Unmap
					state          <= eepc_pkg::EEPC_H_UNMAP;
				end
				eepc_pkg::EEPC_H_UNMAP: begin
					done_out <= 1'b1;
					state    <= eepc_pkg::EEPC_H_IDLE;
				end
				default: state <= eepc_pkg::EEPC_H_IDLE;
			endcase
		end
	end
endmodule : eepc_host

// file: verif/eepc_asserts.sv
// Checker: timing relations on the CPU-to-EEPROM access lines
`timescale 1ns/1ps
module eepc_asserts (
	input wire logic       mclk_in,
	input wire logic       rst_in,
	input wire logic       ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic       xmove_rd,
	input wire logic       xmove_rvalid,
	input wire logic       xram_sel,
	input wire logic       busy_out
);
	localparam int BUSY_MAX = 300;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// ****************************************************************
	// Launch, busy and read relations
	// ****************************************************************
	launch_sets_busy_a: assert property (
		(ctrl_wr && ctrl_wdata[7:4] == 4'h5 && !busy_out) ##1
		(ctrl_wr && ctrl_wdata[7:4] == 4'hA) |-> ##2 busy_out) else $error("no busy after launch");
	busy_holds_a: assert property (
		$rose(busy_out) |-> busy_out[*8]) else $error("busy dropped early");
	busy_ends_a: assert property (
		$rose(busy_out) |-> ##[1:BUSY_MAX] !busy_out) else $error("busy never cleared");
	busy_blocks_read_a: assert property (
		xmove_rd && busy_out |=> !xmove_rvalid) else $error("read answered while busy");
	// The map write lands one edge before the move; the select outputs lag it by one more
	read_answers_a: assert property (
		(ctrl_wr && ctrl_wdata[1] && !busy_out) ##1 xmove_rd |=> xmove_rvalid)
		else $error("mapped read unanswered");
	rvalid_cause_a: assert property (
		xmove_rvalid |-> $past(xmove_rd)) else $error("read data without read");
	// Register view is a copy of the bit, so it shows a write one edge after it is taken
	space_select_a: assert property (
		ctrl_wr && ctrl_wdata[7:4] == 4'h0 |-> ##2 (xram_sel == !ctrl_rdata[1]
		&& ctrl_rdata[1] == $past(ctrl_wdata[1], 2))) else $error("space select wrong");
	busy_bit_a: assert property (
		busy_out |-> ctrl_rdata[0]) else $error("busy bit not shown");
	// Main scenarios seen
	cover property ($rose(busy_out));
	cover property (xmove_rvalid);
	cover property (ctrl_wr && ctrl_wdata == 8'h02);
endmodule : eepc_asserts

// file: verif/tb_top.sv
// Testbench: host and device joined, plus a bench-driven second device
`timescale 1ns/1ps
module tb_top;
	logic        mclk_in, rst_in, req, done, idle, busy, busy2, pdone, got_rv;
	logic [1:0]  op_v;
	logic [10:0] addr;
	logic [7:0]  data, rdata, va, vb, vc, vd, last_exp;
	logic [15:0] seed;
	logic [7:0]  exp_q[$];
	int          n_errors, checks_done, cyc;
	eepc_if bus ();
	eepc_if bus2 ();
	eepc_host eepc_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .bus(bus), .req_in(req),
		.op_in(op_v), .addr_in(addr), .data_in(data), .done_out(done), .rdata_out(rdata),
		.idle_out(idle));
	eepc_device #(.PROG_CYCLES(200)) eepc_device_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.bus(bus), .busy_out(busy), .prog_done_out(pdone));
	// Second device: bench breaks the launch order here
	eepc_device #(.PROG_CYCLES(200)) eepc_device_inst2 (.mclk_in(mclk_in), .rst_in(rst_in),
		.bus(bus2), .busy_out(busy2), .prog_done_out());
	eepc_asserts eepc_asserts_inst (.mclk_in(mclk_in), .rst_in(rst_in), .ctrl_wr(bus.ctrl_wr),
		.ctrl_wdata(bus.ctrl_wdata), .ctrl_rdata(bus.ctrl_rdata), .xmove_rd(bus.xmove_rd),
		.xmove_rvalid(bus.xmove_rvalid), .xram_sel(bus.xram_sel), .busy_out(busy));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] rnd();
		seed ^= seed << 7;
		seed ^= seed >> 9;
		seed ^= seed << 8;
		return seed[7:0];
	endfunction : rnd
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : cmp_byte
	task automatic cmp_bit(input logic g, input logic e, input string m);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : cmp_bit
	task automatic results();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// One host request, bounded wait for done
	task automatic op(input logic [1:0] o, input logic [10:0] a, input logic [7:0] d);
		int i;
		@(posedge mclk_in); #1;
		cmp_bit(idle, 1'b1, "host not idle");
		got_rv = 1'b0;
		{req, op_v, addr, data} = {1'b1, o, a, d};
		@(posedge mclk_in); #1;
		req = 1'b0;
		cmp_bit(idle, 1'b0, "host ignored request");
		i = 0;
		while (done !== 1'b1 && i < 20) begin
			@(posedge mclk_in); #1;
			i++;
		end
		cmp_bit(done, 1'b1, "host done");
		// Host copy of a read answer must match the expected byte popped for that answer
		if (o == 2'd0 && got_rv) begin
			cmp_byte(rdata, last_exp, "host read data");
		end
	endtask : op
	// Busy shows one edge after the launch is taken, so let that edge pass first
	task automatic settle();
		int i;
		logic seen;
		i = 0;
		seen = 1'b0;
		@(posedge mclk_in); #1;
		while (busy !== 1'b0 && i < 400) begin
			@(posedge mclk_in); #1;
			i++;
			seen |= (pdone === 1'b1);
		end
		cmp_bit(busy, 1'b0, "busy stuck");
		cmp_bit(seen, 1'b1, "no end of program pulse");
	endtask : settle
	// Bench drive of the second device for one cycle
	task automatic w2(input logic c, input logic r, input logic [7:0] d);
		@(posedge mclk_in); #1;
		{bus2.ctrl_wr, bus2.xmove_rd, bus2.ctrl_wdata} = {c, r, d};
	endtask : w2
	// ****************************************************************
	// Clock, monitor, timeout
	// ****************************************************************
	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	// Each read answer is matched with the oldest expected byte, mid-cycle once settled
	always @(negedge mclk_in) begin
		if (bus.xmove_rvalid === 1'b1) begin
			got_rv = 1'b1;
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("wrong value at %0t: unexpected read data", $time);
			end else begin
				last_exp = exp_q.pop_front();
				cmp_byte(bus.xmove_rdata, last_exp, "read data");
			end
		end
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst_in, req, op_v, addr, data, n_errors, checks_done, cyc} = {1'b1, 22'h0, 96'h0};
		{bus2.ctrl_wr, bus2.xmove_rd, bus2.xmove_wr, bus2.ctrl_wdata} = 11'h000;
		{bus2.data_pointer, bus2.acc} = 19'h0_0000;
		seed = 16'h636E;
		repeat (4) @(posedge mclk_in);
		#1 rst_in = 1'b0;
		w2(1'b1, 1'b0, 8'h01);
		repeat (2) w2(1'b0, 1'b0, 8'h00);
		cmp_bit(bus2.ctrl_rdata[0], 1'b0, "busy bit written");
		// A move between the two launch writes must abort
		w2(1'b1, 1'b0, 8'h50);
		w2(1'b0, 1'b1, 8'h00);
		w2(1'b1, 1'b0, 8'hA0);
		repeat (3) w2(1'b0, 1'b0, 8'h00);
		cmp_bit(busy2, 1'b0, "aborted launch");
		w2(1'b1, 1'b0, 8'h50);
		w2(1'b1, 1'b0, 8'hA0);
		repeat (3) w2(1'b0, 1'b0, 8'h00);
		cmp_bit(busy2, 1'b1, "launch");
		// First page of a session wins; other-page bytes dropped
		{va, vb, vc, vd} = {rnd(), rnd(), rnd(), rnd()};
		// Dropped bytes must differ from the kept one to be seen
		vb = ~va;
		op(2'd1, {4'h5, 7'h09}, va);
		op(2'd1, {4'h3, 7'h7F}, vb);
		op(2'd2, 11'h000, 8'h00);
		settle();
		exp_q.push_back(va);
		op(2'd0, {4'h5, 7'h09}, 8'h00);
		op(2'd1, {4'h3, 7'h00}, vc);
		op(2'd1, {4'h3, 7'h7F}, vd);
		op(2'd1, {4'h5, 7'h09}, vb);
		op(2'd2, 11'h000, 8'h00);
		@(posedge mclk_in); #1;
		cmp_bit(busy, 1'b1, "busy during program");
		op(2'd0, {4'h3, 7'h00}, 8'h00);
		settle();
		exp_q = {exp_q, vc, vd, va};
		op(2'd0, {4'h3, 7'h00}, 8'h00);
		op(2'd0, {4'h3, 7'h7F}, 8'h00);
		op(2'd0, {4'h5, 7'h09}, 8'h00);
		// Only marked bytes are programmed: a stale latch byte must not reach page 5
		op(2'd1, {4'h3, 7'h09}, vb);
		op(2'd2, 11'h000, 8'h00);
		settle();
		vc = rnd();
		op(2'd1, {4'h5, 7'h00}, vc);
		op(2'd2, 11'h000, 8'h00);
		settle();
		exp_q = {exp_q, va, vc, vd, vb};
		op(2'd0, {4'h5, 7'h09}, 8'h00);
		op(2'd0, {4'h5, 7'h00}, 8'h00);
		op(2'd0, {4'h3, 7'h7F}, 8'h00);
		op(2'd0, {4'h3, 7'h09}, 8'h00);
		repeat (3) @(posedge mclk_in);
		cmp_bit(exp_q.size() == 0, 1'b1, "reads unanswered");
		results();
	end
endmodule : tb_top
